// [hw/sfbp_protect.sv]
// Block protection core: lock maps, freeze flag, pin guard and array gate
`timescale 1ns/100ps
module sfbp_protect #(
    parameter int ADDR_W = sfbp_pkg::ADDR_W_DEF
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic factory_init,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_n,
    input wire logic quad_mode,
    input wire logic pe_req,
    input wire logic [ADDR_W-1:0] pe_addr,
    output logic pe_ok,
    output logic pe_reject,
    input wire logic [ADDR_W-1:0] rd_addr,
    input wire logic [7:0] rd_data_in,
    output logic [7:0] rd_data_out,
    output logic [7:0] status,
    output logic [7:0] cfg_reg,
    output logic [sfbp_pkg::MAP_W-1:0] block_protect_map,
    output logic [sfbp_pkg::NV_W-1:0] permanent_lock_map
);
    import sfbp_pkg::*;

    if (ADDR_W != HI_W + ADDR_HI_LO) begin : g_bad_addr
        $error("ADDR_W must span exactly the block layout");
    end

    sfbp_core_t s_r;
    sfbp_core_t s_nxt;
    sfbp_frame_t link_frame;
    logic [MAP_W-1:0] force_w;
    logic frame_end;
    logic pin_lock;
    logic map_ok;
    logic [7:0] op;
    logic [7:0] plen;
    logic [7:0] pe_j;
    logic [7:0] rd_j;
    logic pe_locked;
    logic rd_locked;

    sfbp_link_rx u_link (
        .sck(sck),
        .cs_n(cs_n),
        .si(si),
        .frame(link_frame)
    );

    // Address to block index: 0..7 parameter, 8/9 the 32K pair, 10.. the 64K run
    function automatic logic [7:0] blk_idx(input logic [ADDR_W-1:0] a);
        logic [HI_W-1:0] hi;
        logic [7:0] sub;
        hi = a[ADDR_W-1:ADDR_HI_LO];
        sub = {6'h00, a[ADDR_SUB_HI:ADDR_SUB_LO]};
        if (hi == HI_BOT) begin
            blk_idx = a[ADDR_HALF] ? NV_32K_BOT : sub;
        end else if (hi == HI_TOP) begin
            blk_idx = a[ADDR_HALF] ? sub + NV_PARAM_HALF : NV_32K_TOP;
        end else begin
            blk_idx = {1'b0, hi} + NV_64K_BASE;
        end
    endfunction : blk_idx

    // Map position of a block's write-lock
    function automatic logic [7:0] wbit(input logic [7:0] j);
        wbit = (j < NV_PARAM_N) ? {j[6:0], 1'b0} : j + NV_PARAM_N;
    endfunction : wbit

    // Map position of a parameter block's read-lock
    function automatic logic [7:0] rbit(input logic [7:0] j);
        rbit = {j[6:0], 1'b1};
    endfunction : rbit

    // Permanent locks pin the matching write-lock bits every cycle
    for (genvar i = 0; i < MAP_W; i++) begin : g_force
        if (i < PARAM_BITS) begin : g_par
            if (i % 2 == 0) begin : g_w
                assign force_w[i] = s_r.nvl[i / 2];
            end else begin : g_r
                assign force_w[i] = 1'b0;
            end
        end else begin : g_blk
            assign force_w[i] = s_r.nvl[i - PARAM_BITS / 2];
        end
    end

    // Frame ends on the rising select seen through the synchroniser
    assign frame_end = s_r.cs_sync[1] & ~s_r.cs_sync[2];
    assign op = link_frame.op;
    assign plen = link_frame.len - OP_BITS;

    // Pin guard: quad mode or the config bit switch it off entirely
    assign pin_lock = ~quad_mode & ~s_r.pin_cfg & s_r.pin_en & ~s_r.wp_sync[1];

    // Freeze wins over any pin state
    assign map_ok = s_r.wel & ~s_r.freeze & ~pin_lock;

    assign pe_j = blk_idx(pe_addr);
    assign rd_j = blk_idx(rd_addr);
    // Pin plays no part here: it never touches program or erase
    assign pe_locked = s_r.lock_map[wbit(pe_j)];
    assign rd_locked = (rd_j < NV_PARAM_N) && s_r.lock_map[rbit(rd_j)];

    always_comb begin
        s_nxt = s_r;
        s_nxt.cs_sync = {s_r.cs_sync[1:0], cs_n};
        s_nxt.wp_sync = {s_r.wp_sync[0], wp_n};
        s_nxt.pe_ok = 1'b0;
        s_nxt.pe_rej = 1'b0;

        if (pe_req) begin
            if (pe_locked) begin
                s_nxt.pe_rej = 1'b1;
            end else begin
                s_nxt.pe_ok = 1'b1;
            end
        end

        s_nxt.rd_data = rd_data_in;
        if (rd_locked) begin
            s_nxt.rd_data = RD_LOCKED;
        end

        if (frame_end) begin
            // Reset-enable is lost on any other command
            if (op != OP_RSTEN) begin
                s_nxt.rsten = 1'b0;
            end
            case (op)
                OP_WR_ENABLE: begin
                    s_nxt.wel = 1'b1;
                end
                OP_WRDI: begin
                    s_nxt.wel = 1'b0;
                end
                OP_WBPR: begin
                    s_nxt.wel = 1'b0;
                    // Short or long payloads are dropped whole
                    if (map_ok && plen == PLEN_MAP) begin
                        s_nxt.lock_map = link_frame.dat;
                    end
                end
                OP_ULBPR: begin
                    s_nxt.wel = 1'b0;
                    if (map_ok) begin
                        s_nxt.lock_map = s_r.lock_map & RLOCK_MASK;
                    end
                end
                OP_FREEZE: begin
                    s_nxt.wel = 1'b0;
                    if (s_r.wel) begin
                        s_nxt.freeze = 1'b1;
                    end
                end
                OP_WRNV: begin
                    s_nxt.wel = 1'b0;
                    // Only ones land; zeros leave both maps alone
                    if (s_r.wel && !s_r.freeze && plen == PLEN_NV) begin
                        s_nxt.nvl = s_r.nvl | link_frame.dat[NV_W-1:0];
                    end
                end
                OP_WRCR: begin
                    s_nxt.wel = 1'b0;
                    if (s_r.wel && !pin_lock && plen == PLEN_CFG) begin
                        s_nxt.pin_cfg = link_frame.dat[CFG_PIN_CFG];
                        s_nxt.pin_en = link_frame.dat[CFG_PIN_EN];
                    end
                end
                OP_RSTEN: begin
                    s_nxt.rsten = 1'b1;
                end
                OP_RST: begin
                    // Freeze and maps survive a software reset
                    if (s_r.rsten) begin
                        s_nxt.wel = 1'b0;
                        s_nxt.pin_cfg = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        s_nxt.lock_map = s_nxt.lock_map | force_w;

        // Hardware and power-on reset share this path
        if (reset) begin
            s_nxt.lock_map = WLOCK_MASK;
            s_nxt.wel = 1'b0;
            s_nxt.freeze = 1'b0;
            s_nxt.pin_cfg = 1'b0;
            s_nxt.rsten = 1'b0;
            s_nxt.cs_sync = CS_IDLE;
            s_nxt.wp_sync = WP_IDLE;
            s_nxt.rd_data = RD_LOCKED;
            s_nxt.pe_ok = 1'b0;
            s_nxt.pe_rej = 1'b0;
        end

        // Non-volatile bits return to factory state only here, save pin_en, which a config write can also clear
        if (factory_init) begin
            s_nxt.nvl = '0;
            s_nxt.pin_en = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    always_comb begin
        status = 8'h00;
        status[STS_WEL] = s_r.wel;
        status[STS_FREEZE] = s_r.freeze;
        cfg_reg = 8'h00;
        cfg_reg[CFG_PIN_CFG] = s_r.pin_cfg;
        cfg_reg[CFG_PIN_EN] = s_r.pin_en;
    end

    assign pe_ok = s_r.pe_ok;
    assign pe_reject = s_r.pe_rej;
    assign rd_data_out = s_r.rd_data;
    assign block_protect_map = s_r.lock_map;
    assign permanent_lock_map = s_r.nvl;

    sequence s_frame(logic [7:0] code);
        frame_end && op == code;
    endsequence

    sequence s_map_kept;
        s_r.lock_map == ($past(s_r.lock_map) | $past(force_w));
    endsequence

    a_reset_locks: assert property (@(posedge clk) reset |=> s_r.lock_map == WLOCK_MASK)
        else $error("write locks not all set after reset");

    a_reset_free: assert property (@(posedge clk) reset |=> !s_r.freeze && !s_r.wel)
        else $error("freeze or write enable survived reset");

    property p_unlock;
        @(posedge clk) disable iff (reset)
        s_frame(OP_ULBPR) ##0 map_ok |=>
            s_r.lock_map == (($past(s_r.lock_map) & RLOCK_MASK) | $past(force_w));
    endproperty
    a_unlock_all: assert property (p_unlock)
        else $error("global unlock left wrong map");

    a_need_wel: assert property (@(posedge clk) disable iff (reset)
        s_frame(OP_WBPR) ##0 !s_r.wel |=> s_map_kept)
        else $error("map written without write enable");

    a_freeze_map: assert property (@(posedge clk) disable iff (reset)
        s_r.freeze |=> s_map_kept)
        else $error("map changed while frozen");

    a_lock_sets: assert property (@(posedge clk) disable iff (reset)
        s_frame(OP_FREEZE) ##0 s_r.wel |=> s_r.freeze [*2])
        else $error("freeze command did not hold the flag");

    a_nv_sticky: assert property (@(posedge clk)
        !factory_init |=> (s_r.nvl & $past(s_r.nvl)) == $past(s_r.nvl))
        else $error("permanent lock bit cleared");

    a_nv_frozen: assert property (@(posedge clk) disable iff (reset)
        s_frame(OP_WRNV) ##0 (s_r.freeze && !factory_init) |=> $stable(s_r.nvl))
        else $error("permanent lock written while frozen");

    a_pin_cfg: assert property (@(posedge clk) disable iff (reset || factory_init)
        s_frame(OP_WRCR) ##0 pin_lock |=> $stable(s_r.pin_cfg) && $stable(s_r.pin_en))
        else $error("config written while pin guards it");

    a_read_zero: assert property (@(posedge clk) disable iff (reset)
        rd_locked |=> rd_data_out == RD_LOCKED)
        else $error("read-locked block returned data");

    a_pe_reject: assert property (@(posedge clk) disable iff (reset)
        pe_req && pe_locked |=> pe_reject && !pe_ok)
        else $error("program into locked block not rejected");

    a_pe_grant: assert property (@(posedge clk) disable iff (reset)
        pe_req && !pe_locked |=> pe_ok && !pe_reject)
        else $error("program into open block refused");

    a_swrst_keep: assert property (@(posedge clk) disable iff (reset)
        s_frame(OP_RST) ##0 s_r.rsten |=>
            !s_r.wel && !s_r.pin_cfg && s_r.freeze == $past(s_r.freeze))
        else $error("software reset handled status wrongly");
endmodule : sfbp_protect

// [hw/sfbp_pkg.sv]
// Constants, carriers and state types of the block protection logic
package sfbp_pkg;
    localparam int MAP_W = 144;
    localparam int NV_W = 136;
    localparam int PARAM_BITS = 16;
    localparam int ADDR_W_DEF = 23;
    localparam int HI_W = 7;
    localparam int ADDR_HI_LO = 16;
    localparam int ADDR_HALF = 15;
    localparam int ADDR_SUB_HI = 14;
    localparam int ADDR_SUB_LO = 13;
    localparam logic [6:0] HI_BOT = 7'h00;
    localparam logic [6:0] HI_TOP = 7'h7f;
    localparam logic [7:0] NV_PARAM_N = 8'h08;
    localparam logic [7:0] NV_PARAM_HALF = 8'h04;
    localparam logic [7:0] NV_32K_BOT = 8'h08;
    localparam logic [7:0] NV_32K_TOP = 8'h09;
    localparam logic [7:0] NV_64K_BASE = 8'h09;
    localparam logic [MAP_W-1:0] WLOCK_MASK = {{(MAP_W - PARAM_BITS){1'b1}}, 16'h5555};
    localparam logic [MAP_W-1:0] RLOCK_MASK = {{(MAP_W - PARAM_BITS){1'b0}}, 16'haaaa};
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_WBPR = 8'h42;
    localparam logic [7:0] OP_ULBPR = 8'h98;
    localparam logic [7:0] OP_FREEZE = 8'h8d;
    localparam logic [7:0] OP_WRNV = 8'he8;
    localparam logic [7:0] OP_WRCR = 8'h01;
    localparam logic [7:0] OP_RSTEN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    localparam logic [7:0] OP_BITS = 8'h08;
    localparam logic [7:0] PLEN_MAP = 8'h90;
    localparam logic [7:0] PLEN_NV = 8'h88;
    localparam logic [7:0] PLEN_CFG = 8'h08;
    localparam logic [7:0] LEN_MAX = 8'hff;
    localparam int STS_WEL = 1;
    localparam int STS_FREEZE = 4;
    localparam int CFG_PIN_CFG = 1;
    localparam int CFG_PIN_EN = 7;
    localparam logic [7:0] RD_LOCKED = 8'h00;
    localparam logic [2:0] CS_IDLE = 3'h7;
    localparam logic [1:0] WP_IDLE = 2'h3;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] len;
        logic [MAP_W-1:0] dat;
    } sfbp_frame_t;

    typedef struct packed {
        logic [MAP_W-1:0] lock_map;
        logic [NV_W-1:0] nvl;
        logic pin_en;
        logic pin_cfg;
        logic wel;
        logic freeze;
        logic rsten;
        logic [2:0] cs_sync;
        logic [1:0] wp_sync;
        logic [7:0] rd_data;
        logic pe_ok;
        logic pe_rej;
    } sfbp_core_t;
endpackage : sfbp_pkg

// [hw/sfbp_link_rx.sv]
// Serial clock side: gathers opcode and payload of one frame
`timescale 1ns/100ps
module sfbp_link_rx (
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output sfbp_pkg::sfbp_frame_t frame
);
    import sfbp_pkg::*;

    sfbp_frame_t f_r;
    sfbp_frame_t f_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;

    always_comb begin
        f_nxt = f_r;
        cnt_nxt = (cnt_r == LEN_MAX) ? cnt_r : cnt_r + 8'h01;
        if (cnt_r < OP_BITS) begin
            f_nxt.op = {f_r.op[6:0], si};
        end else if (cnt_r < LEN_MAX) begin
            f_nxt.dat = {f_r.dat[MAP_W-2:0], si};
        end
        f_nxt.len = cnt_nxt;
    end

    // Only the count clears with select; the frame must survive for the other domain
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // No reset: read only after a frame has ended and the clock stands still
    always_ff @(posedge sck) begin
        f_r <= f_nxt;
    end

    assign frame = f_r;
endmodule : sfbp_link_rx

// [bench/sfbp_host.sv]
// Host model: sends command frames over the serial link
`timescale 1ns/100ps
module sfbp_host (
    output logic sck,
    output logic cs_n,
    output logic si
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end

    task automatic shift(input logic b);
        si = b;
        #62.5 sck = 1'b1;
        #62.5 sck = 1'b0;
    endtask : shift

    // Clock stands low outside frames; data shows inverse of last bit
    task automatic send(input logic [7:0] op, input int n, input logic [143:0] dat);
        #7 cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            shift(op[i]);
        end
        for (int i = n - 1; i >= 0; i--) begin
            shift(dat[i]);
        end
        #62.5 cs_n = 1'b1;
        si = ~si;
        #250;
    endtask : send

    // Write-class commands sent through this task always follow a write-enable
    task automatic wr_cmd(input logic [7:0] op, input int n, input logic [143:0] dat);
        send(sfbp_pkg::OP_WR_ENABLE, 0, '0);
        send(op, n, dat);
    endtask : wr_cmd
endmodule : sfbp_host

// [bench/sfbp_protect_tb.sv]
// Self-checking bench of the block protection core
`timescale 1ns/100ps
module sfbp_protect_tb;
    import sfbp_pkg::*;
    typedef struct packed {
        logic [7:0] bit_i;
        logic [22:0] lock_a;
        logic [22:0] free_a;
    } sfbp_row_t;
    logic clk, reset, factory_init, sck, cs_n, si, wp_n, quad_mode;
    logic pe_req, pe_ok, pe_reject;
    logic [22:0] pe_addr, rd_addr;
    logic [7:0] rd_data_in, rd_data_out, status, cfg_reg;
    logic [MAP_W-1:0] block_protect_map;
    logic [NV_W-1:0] permanent_lock_map;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;
    sfbp_row_t rows [5] = '{'{8'h00, 23'h000000, 23'h002000},
                            '{8'h08, 23'h7f8000, 23'h7fa000},
                            '{8'h10, 23'h008000, 23'h010000},
                            '{8'h11, 23'h7f0000, 23'h7e0000},
                            '{8'h8f, 23'h7e0000, 23'h7f0000}};

    sfbp_host i_host (.sck(sck), .cs_n(cs_n), .si(si));
    sfbp_protect i_dut (.clk(clk), .reset(reset), .factory_init(factory_init), .sck(sck),
        .cs_n(cs_n), .si(si), .wp_n(wp_n), .quad_mode(quad_mode), .pe_req(pe_req),
        .pe_addr(pe_addr), .pe_ok(pe_ok), .pe_reject(pe_reject), .rd_addr(rd_addr),
        .rd_data_in(rd_data_in), .rd_data_out(rd_data_out), .status(status),
        .cfg_reg(cfg_reg), .block_protect_map(block_protect_map),
        .permanent_lock_map(permanent_lock_map));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic conclude();
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // Long frames dominate; ceiling leaves ample margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            conclude();
        end
    end

    task automatic chk_map(input logic [143:0] got, input logic [143:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_map

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic pe(input logic [22:0] a, input logic rej);
        @(negedge clk);
        pe_req = 1'b1;
        pe_addr = a;
        @(negedge clk);
        pe_req = 1'b0;
        chk_byte({6'h00, pe_ok, pe_reject}, {6'h00, ~rej, rej});
    endtask : pe

    task automatic rd(input logic [22:0] a, input logic [7:0] exp);
        @(negedge clk);
        rd_addr = a;
        rd_data_in = 8'h5a;
        @(negedge clk);
        chk_byte(rd_data_out, exp);
    endtask : rd

    task automatic go(input logic [7:0] op, input int n, input logic [143:0] d, input logic we);
        if (we) begin
            i_host.wr_cmd(op, n, d);
        end else begin
            i_host.send(op, n, d);
        end
        repeat (8) @(negedge clk);
    endtask : go

    task automatic hw_reset(input logic fac);
        reset = 1'b1;
        factory_init = fac;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        factory_init = 1'b0;
        repeat (4) @(negedge clk);
    endtask : hw_reset

    initial begin
        wp_n = 1'b1;
        quad_mode = 1'b0;
        pe_req = 1'b0;
        pe_addr = '0;
        rd_addr = '0;
        rd_data_in = 8'h00;
        hw_reset(1'b1);
        chk_map(block_protect_map, WLOCK_MASK);
        chk_byte(status, 8'h00);
        chk_map(144'(permanent_lock_map), '0);
        pe(23'h000000, 1'b1);
        go(OP_WBPR, 144, '0, 1'b0);
        chk_map(block_protect_map, WLOCK_MASK);
        go(OP_WR_ENABLE, 0, '0, 1'b0);
        chk_byte(status, 8'h02);
        go(OP_WRDI, 0, '0, 1'b0);
        chk_byte(status, 8'h00);
        go(OP_WBPR, 144, WLOCK_MASK | RLOCK_MASK, 1'b1);
        go(OP_ULBPR, 0, '0, 1'b1);
        chk_map(block_protect_map, RLOCK_MASK);
        foreach (rows[k]) begin
            go(OP_WBPR, 144, 144'(1) << rows[k].bit_i, 1'b1);
            chk_map(block_protect_map, 144'(1) << rows[k].bit_i);
            pe(rows[k].lock_a, 1'b1);
            pe(rows[k].free_a, 1'b0);
        end
        go(OP_WBPR, 144, 144'h2, 1'b1);
        rd(23'h000100, RD_LOCKED);
        rd(23'h002000, 8'h5a);
        pe(23'h000000, 1'b0);
        go(OP_WRNV, 136, 144'(1) << 10, 1'b1);
        chk_map(144'(permanent_lock_map), 144'(1) << 10);
        go(OP_ULBPR, 0, '0, 1'b1);
        chk_map(block_protect_map, 144'h2 | (144'(1) << 18));
        go(OP_WRNV, 136, '0, 1'b1);
        chk_map(144'(permanent_lock_map), 144'(1) << 10);
        pe(23'h010000, 1'b1);
        go(OP_WRCR, 8, 144'h80, 1'b1);
        chk_byte(cfg_reg, 8'h80);
        wp_n = 1'b0;
        go(OP_WBPR, 144, '1, 1'b1);
        chk_map(block_protect_map, 144'h2 | (144'(1) << 18));
        go(OP_WRCR, 8, 144'h82, 1'b1);
        chk_byte(cfg_reg, 8'h80);
        pe(23'h002000, 1'b0);
        quad_mode = 1'b1;
        go(OP_WBPR, 144, '0, 1'b1);
        chk_map(block_protect_map, 144'(1) << 18);
        quad_mode = 1'b0;
        wp_n = 1'b1;
        go(OP_WRCR, 8, 144'h82, 1'b1);
        wp_n = 1'b0;
        go(OP_WBPR, 144, 144'h4, 1'b1);
        chk_map(block_protect_map, 144'h4 | (144'(1) << 18));
        wp_n = 1'b1;
        go(OP_FREEZE, 0, '0, 1'b0);
        chk_byte(status, 8'h00);
        go(OP_FREEZE, 0, '0, 1'b1);
        chk_byte(status, 8'h10);
        go(OP_WBPR, 144, '0, 1'b1);
        chk_map(block_protect_map, 144'h4 | (144'(1) << 18));
        go(OP_WRNV, 136, 144'(1) << 20, 1'b1);
        chk_map(144'(permanent_lock_map), 144'(1) << 10);
        go(OP_WRCR, 8, 144'h80, 1'b1);
        chk_byte(cfg_reg, 8'h80);
        // Pin config and write enable set so the software reset has work to do
        go(OP_WRCR, 8, 144'h82, 1'b1);
        go(OP_WR_ENABLE, 0, '0, 1'b0);
        go(OP_RSTEN, 0, '0, 1'b0);
        go(OP_RST, 0, '0, 1'b0);
        chk_byte(status, 8'h10);
        chk_byte(cfg_reg, 8'h80);
        hw_reset(1'b0);
        chk_byte(status, 8'h00);
        chk_map(block_protect_map, WLOCK_MASK);
        chk_byte(cfg_reg, 8'h80);
        go(OP_WRNV, 136, 144'(1) << 20, 1'b1);
        chk_map(144'(permanent_lock_map), (144'(1) << 10) | (144'(1) << 20));
        conclude();
    end
endmodule : sfbp_protect_tb
